// file: pcc_cfg.svh
// Purpose: constants for the copper control and status register pair
// Assumes: 10 MHz system clock
// Notes: offsets are management register numbers
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

`define PCC_ADDR_W 5
`define PCC_DATA_W 16
`define PCC_OFS_CTRL 5'h00
`define PCC_OFS_STAT 5'h01

// control bit positions
`define PCC_CB_SRST 15
`define PCC_CB_SPD_LSB 13
`define PCC_CB_PWRDN 11
`define PCC_CB_RESTART 9
`define PCC_CB_DUPLEX 8
`define PCC_CB_COLTEST 7
`define PCC_CB_SPD_MSB 6

// status bit positions
`define PCC_SB_ANEG_DONE 5
`define PCC_SB_RFAULT 4
`define PCC_SB_LINK 2
`define PCC_SB_JABBER 1

// fixed status bits: abilities, extended status, preamble suppression
`define PCC_STAT_FIXED 16'h7949

// reset values
`define PCC_RST_DUPLEX 1'h1
`define PCC_RST_SPEED 2'h2
`define PCC_RST_PWRDN 1'h0

// software reset duration
`define PCC_CLK_NS 100
`define PCC_SRST_NS 1000
`define PCC_SRST_CYC ((`PCC_SRST_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`define PCC_CNT_W 8

`endif

// file: pcc_pkg.sv
// Purpose: types for the copper control and status register pair
// Assumes: constants come from pcc_cfg.svh
// Notes: none
`include "pcc_cfg.svh"
package pcc_pkg;
   typedef struct packed {
      logic aneg_done;
      logic remote_fault;
      logic link_up;
      logic jabber;
   } pcc_cond_t;

   typedef struct packed {
      logic [`PCC_ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [`PCC_DATA_W-1:0] wdata;
   } pcc_mgmt_req_t;

   typedef enum logic {
      PCC_RUN = 1'b0,
      PCC_SRST = 1'b1
   } pcc_state_t;
endpackage

// file: pcc_regs.sv
// Purpose: copper control (reset, speed, power down, restart, duplex, coltest) and status regs
// Assumes: management requests are decoded frames on the system clock
// Notes: hw negotiation request is an asynchronous pin
`timescale 1ns/1ps
`include "pcc_cfg.svh"
module pcc_regs
   import pcc_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire pcc_mgmt_req_t MGMT_REQ,
   output logic [`PCC_DATA_W-1:0] MGMT_RDATA,
   output logic MGMT_RVALID,
   input wire logic HW_NEGOTIATION_REQUEST_INPUT,
   input wire pcc_cond_t PHY_COND,
   output logic ANEG_RESTART,
   output logic SOFT_RESET,
   output logic POWER_DOWN,
   output logic ACTIVE_DUPLEX,
   output logic [1:0] ACTIVE_SPEED
);
   localparam int SRST_LEN = `PCC_SRST_CYC;
   localparam int SRST_HOLD = SRST_LEN - 1;
   localparam int CNT_W = `PCC_CNT_W;
   localparam logic [CNT_W-1:0] SRST_LAST = CNT_W'(SRST_HOLD);

   logic sync1_q, sync2_q, sync3_q, req_lvl_q, req_lvl_d;
   logic init_q, init_d;
   pcc_state_t st_q, st_d;
   logic [`PCC_CNT_W-1:0] cnt_q, cnt_d;
   logic restart_q, restart_d, aneg_q, aneg_d;
   logic pd_q, pd_d;
   logic dup_q, dup_d, act_dup_q, act_dup_d;
   logic [1:0] spd_q, spd_d, act_spd_q, act_spd_d;
   logic anc_q, anc_d, rf_q, rf_d, link_q, link_d, jab_q, jab_d;
   logic [`PCC_DATA_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic req_rise, ctrl_wr, stat_rd, srst_start, srst_done, load;

   // pin synchroniser, only the 2nd and 3rd stages are compared
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= HW_NEGOTIATION_REQUEST_INPUT;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always_comb begin
      req_lvl_d = req_lvl_q;
      if (sync2_q == sync3_q) begin
         req_lvl_d = sync2_q;
      end
      req_rise = req_lvl_d & ~req_lvl_q;
      ctrl_wr = MGMT_REQ.wr && (MGMT_REQ.addr == `PCC_OFS_CTRL);
      stat_rd = MGMT_REQ.rd && (MGMT_REQ.addr == `PCC_OFS_STAT);
      init_d = 1'b0;
      st_d = st_q;
      cnt_d = cnt_q;
      pd_d = pd_q;
      dup_d = dup_q;
      spd_d = spd_q;
      if (ctrl_wr) begin
         pd_d = MGMT_REQ.wdata[`PCC_CB_PWRDN];
         dup_d = MGMT_REQ.wdata[`PCC_CB_DUPLEX];
         spd_d = {MGMT_REQ.wdata[`PCC_CB_SPD_MSB],
                  MGMT_REQ.wdata[`PCC_CB_SPD_LSB]};
      end
      // explicit reset request or power-down exit
      srst_start = (st_q == PCC_RUN) && ctrl_wr &&
         (MGMT_REQ.wdata[`PCC_CB_SRST] || (pd_q && !pd_d));
      srst_done = 1'b0;
      case (st_q)
         PCC_RUN: begin
            if (srst_start) begin
               st_d = PCC_SRST;
               cnt_d = SRST_LAST;
            end
         end
         PCC_SRST: begin
            if (cnt_q == '0) begin
               st_d = PCC_RUN;
               srst_done = 1'b1;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: st_d = PCC_RUN;
      endcase
      // a restart fires once out of reset; new requests win over the clear
      aneg_d = restart_q && (st_q == PCC_RUN);
      restart_d = restart_q && !aneg_d;
      if ((ctrl_wr && MGMT_REQ.wdata[`PCC_CB_RESTART]) || req_rise ||
          init_q || srst_done) begin
         restart_d = 1'b1;
      end
      load = srst_start || aneg_d;
      act_dup_d = load ? dup_d : act_dup_q;
      act_spd_d = load ? spd_d : act_spd_q;
      // status: negotiation complete is live, others latching; conditions set ahead of read clears
      anc_d = PHY_COND.aneg_done;
      rf_d = PHY_COND.remote_fault | (rf_q & ~stat_rd);
      jab_d = PHY_COND.jabber | (jab_q & ~stat_rd);
      link_d = stat_rd ? PHY_COND.link_up :
         (link_q & PHY_COND.link_up);
      if (srst_start || st_q == PCC_SRST) begin
         anc_d = 1'b0;
         rf_d = 1'b0;
         jab_d = 1'b0;
         link_d = 1'b0;
      end
      rdata_d = '0;
      if (MGMT_REQ.rd && MGMT_REQ.addr == `PCC_OFS_CTRL) begin
         rdata_d[`PCC_CB_SRST] = (st_q == PCC_SRST);
         rdata_d[`PCC_CB_SPD_LSB] = spd_q[0];
         rdata_d[`PCC_CB_PWRDN] = pd_q;
         rdata_d[`PCC_CB_RESTART] = restart_q;
         rdata_d[`PCC_CB_DUPLEX] = dup_q;
         rdata_d[`PCC_CB_COLTEST] = 1'b0;
         rdata_d[`PCC_CB_SPD_MSB] = spd_q[1];
      end else if (stat_rd) begin
         rdata_d = `PCC_STAT_FIXED;
         rdata_d[`PCC_SB_ANEG_DONE] = anc_q;
         rdata_d[`PCC_SB_RFAULT] = rf_q;
         rdata_d[`PCC_SB_LINK] = link_q;
         rdata_d[`PCC_SB_JABBER] = jab_q;
      end
      rvalid_d = MGMT_REQ.rd;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         req_lvl_q <= 1'b0;
         init_q <= 1'b1;
         st_q <= PCC_RUN;
         cnt_q <= '0;
         restart_q <= 1'b0;
         aneg_q <= 1'b0;
         pd_q <= `PCC_RST_PWRDN;
         dup_q <= `PCC_RST_DUPLEX;
         spd_q <= `PCC_RST_SPEED;
         act_dup_q <= `PCC_RST_DUPLEX;
         act_spd_q <= `PCC_RST_SPEED;
         anc_q <= 1'b0;
         rf_q <= 1'b0;
         link_q <= 1'b0;
         jab_q <= 1'b0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         req_lvl_q <= req_lvl_d;
         init_q <= init_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         restart_q <= restart_d;
         aneg_q <= aneg_d;
         pd_q <= pd_d;
         dup_q <= dup_d;
         spd_q <= spd_d;
         act_dup_q <= act_dup_d;
         act_spd_q <= act_spd_d;
         anc_q <= anc_d;
         rf_q <= rf_d;
         link_q <= link_d;
         jab_q <= jab_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign MGMT_RDATA = rdata_q;
   assign MGMT_RVALID = rvalid_q;
   assign ANEG_RESTART = aneg_q;
   assign SOFT_RESET = (st_q == PCC_SRST);
   assign POWER_DOWN = pd_q;
   assign ACTIVE_DUPLEX = act_dup_q;
   assign ACTIVE_SPEED = act_spd_q;

   chk_restart_pulse: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      restart_q && st_q == PCC_RUN |=> ANEG_RESTART)
      else $error("restart bit did not pulse negotiation");
   chk_hwreq_sets: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      req_rise |=> restart_q)
      else $error("hw request edge did not set restart");
   chk_srst_aneg: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $fell(SOFT_RESET) |-> restart_q ##1 ANEG_RESTART)
      else $error("no negotiation restart after soft reset");
   chk_dup_defer: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $changed(ACTIVE_DUPLEX) |-> $past(load))
      else $error("duplex changed without update event");
   chk_spd_defer: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $changed(ACTIVE_SPEED) |-> $past(load))
      else $error("speed changed without update event");
   chk_coll_zero: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      MGMT_RVALID |-> !MGMT_RDATA[`PCC_CB_COLTEST])
      else $error("collision test bit read as one");
   chk_stat_fixed: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      stat_rd |=> MGMT_RVALID && (MGMT_RDATA & 16'hFFC9) == `PCC_STAT_FIXED)
      else $error("fixed status bits wrong");
   chk_anc_live: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      st_q == PCC_RUN && !srst_start |=> anc_q == $past(PHY_COND.aneg_done))
      else $error("negotiation complete not live");
   chk_rf_latch: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      PHY_COND.remote_fault && st_q == PCC_RUN && !srst_start |=> rf_q)
      else $error("remote fault not latched");
   chk_link_low: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      !PHY_COND.link_up |=> !link_q)
      else $error("link down not latched low");
   chk_jab_hold: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      jab_q && !stat_rd && st_q == PCC_RUN && !srst_start |=> jab_q)
      else $error("jabber latch lost before read");
   chk_srst_len: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(SOFT_RESET) |-> ##SRST_HOLD SOFT_RESET ##1 !SOFT_RESET)
      else $error("soft reset length wrong");
   chk_pd_exit: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $fell(POWER_DOWN) && !$past(SOFT_RESET) |-> SOFT_RESET)
      else $error("power down exit without soft reset");
   chk_read_clear: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      stat_rd && !PHY_COND.remote_fault |=> !rf_q)
      else $error("remote fault not cleared by read");
endmodule // pcc_regs

// file: pcc_station.sv
// Purpose: management station model issuing decoded requests
// Assumes: one request per cycle, answer one cycle after rd
// Notes: idle request is all zero
`timescale 1ns/1ps
module pcc_station
   import pcc_pkg::*;
(
   input wire logic clk,
   output pcc_mgmt_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   initial req = '0;
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      v = (rvalid === 1'b1) ? rdata : 16'hXXXX;
   endtask
endmodule // pcc_station

// file: testbench.sv
// Purpose: self-checking bench for the copper control and status pair
// Assumes: station model issues requests, bench drives conditions
// Notes: expected values come from bench variables and constants only
`timescale 1ns/1ps
module testbench import pcc_pkg::*; ();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hw = 1'b0;
   pcc_cond_t cond = '0;
   pcc_mgmt_req_t req;
   logic [15:0] rdata, d, w;
   logic rvalid, rstrt, srst, pd, dup;
   logic [1:0] spd;
   logic [31:0] rng = 32'h0000005E;
   int n_errors = 0, samples_checked = 0, n_rs = 0, n_sr = 0, cyc = 0;
   int m_dup = 1, m_spd = 2, lh_rf = 0, lh_jb = 0, ll_lk = 0, rs0, sr0;

   pcc_regs i_dut(.CLK_SYS(clk), .RST_N(rst_n), .MGMT_REQ(req),
      .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid),
      .HW_NEGOTIATION_REQUEST_INPUT(hw), .PHY_COND(cond),
      .ANEG_RESTART(rstrt), .SOFT_RESET(srst), .POWER_DOWN(pd),
      .ACTIVE_DUPLEX(dup), .ACTIVE_SPEED(spd));
   pcc_station i_sta(.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t read exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_out(input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t output exp %h got %h", $time, e, g);
      end
   endtask
   task automatic rd_stat();
      logic [15:0] s, e;
      e = 16'h7949 | 16'(cond.aneg_done) << 5 | 16'(lh_rf) << 4;
      e = e | 16'(ll_lk) << 2 | 16'(lh_jb) << 1;
      i_sta.rd(5'h01, s);
      chk_rd(e, s);
      lh_rf = cond.remote_fault;
      lh_jb = cond.jabber;
      ll_lk = cond.link_up;
   endtask
   task automatic apply(input logic [15:0] v, input int n_exp);
      rs0 = n_rs;
      sr0 = n_sr;
      i_sta.wr(5'h00, v);
      repeat (16) @(posedge clk);
      chk_out(16'(n_exp), 16'(n_sr - sr0));
      chk_out(16'h0001, 16'(n_rs - rs0));
      chk_out(16'(m_dup * 4 + m_spd), {13'h0000, dup, spd});
      if (n_exp != 0) begin
         lh_rf = 0;
         lh_jb = 0;
         ll_lk = 0;
      end
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      cond[k] <= ~cond[k];
      repeat (2) @(posedge clk);
      cond[k] <= ~cond[k];
      repeat (2) @(posedge clk);
      if (k == 2) lh_rf = 1;
      else if (k == 0) lh_jb = 1;
      else ll_lk = 0;
   endtask

   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (rstrt === 1'b1) n_rs++;
      if (srst === 1'b1) n_sr++;
      if (cyc == 3000) begin
         n_errors++;
         $display("ERROR %0t timeout", $time);
         end_of_test();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk_out(16'h0001, 16'(n_rs));
      i_sta.rd(5'h00, d);
      chk_rd(16'h0140, d);
      rd_stat();
      i_sta.rd(5'h1F, d);
      chk_rd(16'h0000, d);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         w = {2'b00, i[0], 4'h0, rng[0], 1'b1, i[1], 6'h00};
         i_sta.wr(5'h00, w);
         chk_out(16'(m_dup * 4 + m_spd), {13'h0000, dup, spd});
         i_sta.rd(5'h00, d);
         chk_rd(w & 16'h2140, d);
         m_dup = int'(rng[0]);
         m_spd = i % 4;
         apply(w | (i < 4 ? 16'h0200 : 16'h8000), i < 4 ? 0 : 10);
         i_sta.rd(5'h00, d);
         chk_rd(w & 16'h2140, d);
      end
      i_sta.wr(5'h00, w | 16'h0800);
      chk_out(16'h0001, 16'(pd));
      apply(w, 10);
      $display("control test done");
      rs0 = n_rs;
      @(posedge clk);
      hw <= 1'b1;
      repeat (10) @(posedge clk);
      hw <= 1'b0;
      chk_out(16'h0001, 16'(n_rs - rs0));
      @(posedge clk);
      cond <= 4'hA;
      repeat (2) @(posedge clk);
      rd_stat();
      rd_stat();
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         pulse(int'(rng % 3));
         rd_stat();
         rd_stat();
      end
      $display("latch test done");
      end_of_test();
   end
endmodule // testbench
